// ### hdl/nand_feature_defs.vh
/*
 Constants for the serial NAND status, driver-strength and internal ECC block:
 command codes, feature addresses, field positions, reset values and timing.
 Assumes inclusion by bare name from files that need these numbers.
*/
`ifndef NAND_FEATURE_DEFS_VH
`define NAND_FEATURE_DEFS_VH

`define CMD_WRITE_EN      8'h06
`define CMD_WRITE_DIS     8'h04
`define CMD_GET_FEAT      8'h0F
`define CMD_SET_FEAT      8'h1F
`define CMD_PROG_EXEC     8'h10
`define CMD_BLOCK_ERASE   8'hD8
`define CMD_PAGE_READ     8'h13
`define CMD_RESET         8'hFF

`define FA_STATUS_A       8'hC0
`define FA_STATUS_B       8'hF0
`define FA_DRIVER         8'hD0
`define FA_FEATURE        8'hB0

`define ST_BUSY           0
`define ST_WRITE_LATCH    1
`define ST_ERASE_FAIL     2
`define ST_PROG_FAIL      3
`define ST_OUTCOME_LO     4
`define ST_OUTCOME_HI     5
`define ST_COUNT_LO       6
`define ST_COUNT_HI       7

`define DRV_LO            5
`define DRV_HI            6
`define DRV_RESET         2'h0
`define FEAT_ECC_EN       4
`define ECC_EN_RESET      1'h1

`define COL_SPARE_BASE    12'h800
`define COL_PARITY_BASE   12'h840
`define COL_PARITY_LAST   12'h87F
`define COL_BAD_MARK      12'h800
`define ECC_CAPABILITY    4'h8

`define SYS_CLK_MHZ       100
`define RST_QUIET_NS      300
`define RST_QUIET_CYC     ((`RST_QUIET_NS * `SYS_CLK_MHZ + 999) / 1000)
`endif

// ### hdl/spi_pin_sync.v
/*
 Two-flop synchronisers for the serial pins plus edge detection of the serial
 clock and chip select. Assumes mode 0 signalling with the serial clock idle low.
*/
`timescale 1ns/1ps
module spi_pin_sync (
    input  wire i_sys_clk,
    input  wire i_rstn,
    input  wire i_sclk,
    input  wire i_cs_n,
    input  wire i_mosi,
    output wire o_sclk_rise,
    output wire o_sclk_fall,
    output wire o_cs_act,
    output wire o_cs_end,
    output wire o_mosi
);

    wire [2:0] pins;
    reg  [2:0] meta;
    reg  [2:0] stab;
    reg  [2:0] prev;

    assign pins = {i_mosi, i_cs_n, i_sclk};

    // idle pattern: select high, clock and data low
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : g_sync
            always @(posedge i_sys_clk or negedge i_rstn) begin
                if (!i_rstn) begin
                    meta[g] <= (g == 1) ? 1'b1 : 1'b0;
                    stab[g] <= (g == 1) ? 1'b1 : 1'b0;
                    prev[g] <= (g == 1) ? 1'b1 : 1'b0;
                end else begin
                    meta[g] <= pins[g];
                    stab[g] <= meta[g];
                    prev[g] <= stab[g];
                end
            end
        end
    endgenerate

    // edges come from the second and third stage only
    assign o_sclk_rise = stab[0] & ~prev[0] & ~stab[1];
    assign o_sclk_fall = ~stab[0] & prev[0] & ~stab[1];
    assign o_cs_act    = ~stab[1];
    assign o_cs_end    = stab[1] & ~prev[1];
    assign o_mosi      = stab[2];

endmodule // spi_pin_sync

// ### hdl/nand_status_ecc_features.v
/*
 Status, driver-strength and internal ECC feature logic of a serial NAND device.
 Decodes write enable/disable, get/set features, program execute, block erase,
 page read and reset from the serial pins, keeps the status byte and hands
 array operations to an array engine on the same clock.
 Assumes the engine latches o_row_addr at its start pulse, answers with a
 one-cycle i_op_done carrying i_op_fail and i_ecc_bits, and that
 i_target_locked is valid for o_row_addr from the protection logic.
*/
`timescale 1ns/1ps
`include "nand_feature_defs.vh"
module nand_status_ecc_features #(
    parameter ROW_W = 24
) (
    input  wire             i_sys_clk,
    input  wire             i_rstn,
    input  wire             i_sclk,
    input  wire             i_cs_n,
    input  wire             i_mosi,
    output reg              o_miso,
    output reg              o_miso_oe,
    input  wire             i_op_done,
    input  wire             i_op_fail,
    input  wire [3:0]       i_ecc_bits,
    input  wire             i_target_locked,
    input  wire [11:0]      i_col_addr,
    output reg              o_prog_start,
    output reg              o_erase_start,
    output reg              o_read_start,
    output reg              o_reset_start,
    output reg  [ROW_W-1:0] o_row_addr,
    output reg              o_ecc_enable,
    output reg  [1:0]       o_drive_strength,
    output reg  [6:0]       o_drive_percent,
    output reg              o_col_protected,
    output reg              o_col_parity,
    output reg              o_col_bad_mark
);

    localparam S_CMD  = 5'b00001;
    localparam S_ADDR = 5'b00010;
    localparam S_DATA = 5'b00100;
    localparam S_OUT  = 5'b01000;
    localparam S_SKIP = 5'b10000;

    localparam OP_IDLE  = 4'b0000;
    localparam OP_PROG  = 4'b0001;
    localparam OP_ERASE = 4'b0010;
    localparam OP_READ  = 4'b0100;
    localparam OP_RESET = 4'b1000;

    localparam integer RST_CYC_N = `RST_QUIET_CYC;
    localparam [4:0]   RST_CYC   = RST_CYC_N[4:0];

    wire       sclk_rise;
    wire       sclk_fall;
    wire       cs_act;
    wire       cs_end;
    wire       mosi_s;

    reg  [4:0] state;
    reg  [2:0] bit_cnt;
    reg  [1:0] addr_cnt;
    reg  [6:0] rx;
    reg  [7:0] cmd;
    reg  [7:0] faddr;
    reg  [2:0] out_cnt;
    reg  [7:0] tx_sh;
    reg        exec_pend;

    reg        operation_busy_flag;
    reg        write_latch_flag;
    reg        prog_fail;
    reg        erase_fail;
    reg  [1:0] ecc_outcome;
    reg  [1:0] ecc_count;
    reg  [3:0] op;
    reg  [4:0] rst_wait;
    reg        por_pend;
    reg        done_seen;
    reg        fail_seen;
    reg  [3:0] ecc_seen;

    reg  [7:0] status_val;
    reg  [7:0] live_val;

    wire [7:0] rx_byte;
    wire       byte_done;
    wire       cmd_byte;
    wire       do_reset;
    wire       do_wren;
    wire       do_wrdi;
    wire       feat_wr;
    wire       go;
    wire       finish;

    spi_pin_sync u_sync (
        .i_sys_clk   (i_sys_clk),
        .i_rstn      (i_rstn),
        .i_sclk      (i_sclk),
        .i_cs_n      (i_cs_n),
        .i_mosi      (i_mosi),
        .o_sclk_rise (sclk_rise),
        .o_sclk_fall (sclk_fall),
        .o_cs_act    (cs_act),
        .o_cs_end    (cs_end),
        .o_mosi      (mosi_s)
    );

    function is_status_addr;
        input [7:0] a;
        begin
            is_status_addr = (a == `FA_STATUS_A) || (a == `FA_STATUS_B);
        end
    endfunction

    function is_array_cmd;
        input [7:0] c;
        begin
            is_array_cmd = (c == `CMD_PROG_EXEC) || (c == `CMD_BLOCK_ERASE) ||
                           (c == `CMD_PAGE_READ);
        end
    endfunction

    // {count, outcome} from the number of bit errors the engine saw
    function [3:0] ecc_code;
        input [3:0] n;
        begin
            if (n == 4'h0)
                ecc_code = 4'h0;
            else if (n <= 4'h4)
                ecc_code = 4'h1;
            else if (n < `ECC_CAPABILITY)
                ecc_code = {n[1:0] - 2'h0, 2'h1};
            else if (n == `ECC_CAPABILITY)
                ecc_code = 4'h3;
            else
                ecc_code = 4'h2;
        end
    endfunction

    function [6:0] drive_pct;
        input [1:0] ds;
        begin
            if (ds == 2'h0)
                drive_pct = 7'h32;
            else if (ds == 2'h1)
                drive_pct = 7'h19;
            else if (ds == 2'h2)
                drive_pct = 7'h4B;
            else
                drive_pct = 7'h64;
        end
    endfunction

    assign rx_byte   = {rx, mosi_s};
    assign byte_done = sclk_rise && cs_act && (bit_cnt == 3'h7);
    assign cmd_byte  = byte_done && (state == S_CMD);
    assign do_reset  = cmd_byte && (rx_byte == `CMD_RESET);
    assign do_wren   = cmd_byte && (rx_byte == `CMD_WRITE_EN) && !operation_busy_flag;
    assign do_wrdi   = cmd_byte && (rx_byte == `CMD_WRITE_DIS) && !operation_busy_flag;
    assign feat_wr   = byte_done && (state == S_DATA);
    assign go        = cs_end && exec_pend && !operation_busy_flag;
    assign finish    = operation_busy_flag && done_seen && (rst_wait == 5'h0) && !por_pend;

    // status byte is one value whichever status address selects it
    always @* begin
        status_val                  = 8'h00;
        status_val[`ST_BUSY]        = operation_busy_flag;
        status_val[`ST_WRITE_LATCH] = write_latch_flag;
        status_val[`ST_ERASE_FAIL]  = erase_fail;
        status_val[`ST_PROG_FAIL]   = prog_fail;
        status_val[`ST_OUTCOME_LO]  = ecc_outcome[0];
        status_val[`ST_OUTCOME_HI]  = ecc_outcome[1];
        status_val[`ST_COUNT_LO]    = ecc_count[0];
        status_val[`ST_COUNT_HI]    = ecc_count[1];
    end

    always @* begin
        live_val = 8'h00;
        if (is_status_addr(faddr)) begin
            live_val = status_val;
        end else if (faddr == `FA_DRIVER) begin
            live_val[`DRV_LO] = o_drive_strength[0];
            live_val[`DRV_HI] = o_drive_strength[1];
        end else if (faddr == `FA_FEATURE) begin
            live_val[`FEAT_ECC_EN] = o_ecc_enable;
        end
    end

    // serial front end: byte assembly, command routing, read-back shifting
    always @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state      <= S_CMD;
            bit_cnt    <= 3'h0;
            addr_cnt   <= 2'h0;
            rx         <= 7'h00;
            cmd        <= 8'h00;
            faddr      <= 8'h00;
            out_cnt    <= 3'h0;
            tx_sh      <= 8'h00;
            exec_pend  <= 1'b0;
            o_row_addr <= {ROW_W{1'b0}};
            o_miso     <= 1'b0;
            o_miso_oe  <= 1'b0;
        end else if (!cs_act) begin
            state     <= S_CMD;
            bit_cnt   <= 3'h0;
            addr_cnt  <= 2'h0;
            out_cnt   <= 3'h0;
            exec_pend <= 1'b0;
            o_miso_oe <= 1'b0;
        end else begin
            if (sclk_rise) begin
                rx      <= rx_byte[6:0];
                bit_cnt <= bit_cnt + 3'h1;
            end
            if (byte_done) begin
                case (state)
                    S_CMD: begin
                        cmd <= rx_byte;
                        if ((rx_byte == `CMD_GET_FEAT) || (rx_byte == `CMD_SET_FEAT))
                            state <= S_ADDR;
                        else if (is_array_cmd(rx_byte))
                            state <= S_ADDR;
                        else
                            state <= S_SKIP;
                    end
                    S_ADDR: begin
                        if (cmd == `CMD_GET_FEAT) begin
                            faddr <= rx_byte;
                            state <= S_OUT;
                        end else if (cmd == `CMD_SET_FEAT) begin
                            faddr <= rx_byte;
                            state <= S_DATA;
                        end else begin
                            // a new row is ignored while the engine works
                            if (!operation_busy_flag)
                                o_row_addr <= {o_row_addr[ROW_W-9:0], rx_byte};
                            addr_cnt <= addr_cnt + 2'h1;
                            if (addr_cnt == 2'h2) begin
                                exec_pend <= 1'b1;
                                state     <= S_SKIP;
                            end
                        end
                    end
                    S_DATA: begin
                        state <= S_SKIP;
                    end
                    default: begin
                        state <= state;
                    end
                endcase
            end
            // reload every eighth bit so a polled status stays current
            if (sclk_fall && (state == S_OUT)) begin
                o_miso_oe <= 1'b1;
                out_cnt   <= out_cnt + 3'h1;
                if (out_cnt == 3'h0) begin
                    o_miso <= live_val[7];
                    tx_sh  <= {live_val[6:0], 1'b0};
                end else begin
                    o_miso <= tx_sh[7];
                    tx_sh  <= {tx_sh[6:0], 1'b0};
                end
            end
        end
    end

    // status flags, feature bits and array operation sequencing
    always @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            operation_busy_flag <= 1'b1;
            write_latch_flag    <= 1'b0;
            prog_fail           <= 1'b0;
            erase_fail          <= 1'b0;
            ecc_outcome         <= 2'h0;
            ecc_count           <= 2'h0;
            op                  <= OP_IDLE;
            rst_wait            <= 5'h0;
            por_pend            <= 1'b1;
            done_seen           <= 1'b0;
            fail_seen           <= 1'b0;
            ecc_seen            <= 4'h0;
            o_prog_start        <= 1'b0;
            o_erase_start       <= 1'b0;
            o_read_start        <= 1'b0;
            o_reset_start       <= 1'b0;
            o_ecc_enable        <= `ECC_EN_RESET;
            o_drive_strength    <= `DRV_RESET;
        end else begin
            o_prog_start  <= 1'b0;
            o_erase_start <= 1'b0;
            o_read_start  <= 1'b0;
            o_reset_start <= 1'b0;
            if (rst_wait != 5'h0)
                rst_wait <= rst_wait - 5'h1;
            if (i_op_done && operation_busy_flag) begin
                done_seen <= 1'b1;
                fail_seen <= i_op_fail;
                ecc_seen  <= i_ecc_bits;
            end
            if (feat_wr) begin
                if (faddr == `FA_DRIVER)
                    o_drive_strength <= {rx_byte[`DRV_HI], rx_byte[`DRV_LO]};
                else if (faddr == `FA_FEATURE)
                    o_ecc_enable <= rx_byte[`FEAT_ECC_EN];
            end
            if (por_pend) begin
                // power-on page read of row zero fills ECC status
                por_pend     <= 1'b0;
                op           <= OP_READ;
                o_read_start <= 1'b1;
            end else if (do_reset) begin
                prog_fail           <= 1'b0;
                erase_fail          <= 1'b0;
                ecc_outcome         <= 2'h0;
                ecc_count           <= 2'h0;
                operation_busy_flag <= 1'b1;
                op                  <= OP_RESET;
                o_reset_start       <= 1'b1;
                rst_wait            <= RST_CYC;
                done_seen           <= 1'b0;
            end else if (do_wren) begin
                write_latch_flag <= 1'b1;
            end else if (do_wrdi) begin
                write_latch_flag <= 1'b0;
            end else if (go) begin
                done_seen <= 1'b0;
                if ((cmd == `CMD_PROG_EXEC) && write_latch_flag) begin
                    if (i_target_locked) begin
                        prog_fail <= 1'b1;
                    end else begin
                        prog_fail           <= 1'b0;
                        operation_busy_flag <= 1'b1;
                        op                  <= OP_PROG;
                        o_prog_start        <= 1'b1;
                    end
                end else if ((cmd == `CMD_BLOCK_ERASE) && write_latch_flag) begin
                    if (i_target_locked) begin
                        erase_fail <= 1'b1;
                    end else begin
                        erase_fail          <= 1'b0;
                        operation_busy_flag <= 1'b1;
                        op                  <= OP_ERASE;
                        o_erase_start       <= 1'b1;
                    end
                end else if (cmd == `CMD_PAGE_READ) begin
                    ecc_outcome         <= 2'h0;
                    ecc_count           <= 2'h0;
                    operation_busy_flag <= 1'b1;
                    op                  <= OP_READ;
                    o_read_start        <= 1'b1;
                end
            end else if (finish) begin
                operation_busy_flag <= 1'b0;
                done_seen           <= 1'b0;
                op                  <= OP_IDLE;
                case (op)
                    OP_PROG: begin
                        prog_fail        <= fail_seen;
                        write_latch_flag <= 1'b0;
                    end
                    OP_ERASE: begin
                        erase_fail       <= fail_seen;
                        write_latch_flag <= 1'b0;
                    end
                    OP_READ: begin
                        // with ECC off the fields stay 00 and mean nothing
                        if (o_ecc_enable)
                            {ecc_count, ecc_outcome} <= ecc_code(ecc_seen);
                    end
                    default: begin
                        op <= OP_IDLE;
                    end
                endcase
            end
        end
    end

    always @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn)
            o_drive_percent <= 7'h32;
        else
            o_drive_percent <= drive_pct(o_drive_strength);
    end

    // column map: parity bytes are rebuilt inside, first spare quads open
    always @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_col_protected <= 1'b0;
            o_col_parity    <= 1'b0;
            o_col_bad_mark  <= 1'b0;
        end else begin
            o_col_parity <= (i_col_addr >= `COL_PARITY_BASE) &&
                            (i_col_addr <= `COL_PARITY_LAST);
            if (i_col_addr < `COL_SPARE_BASE)
                o_col_protected <= 1'b1;
            else if (i_col_addr < `COL_PARITY_BASE)
                o_col_protected <= (i_col_addr[3:2] != 2'h0);
            else
                o_col_protected <= (i_col_addr <= `COL_PARITY_LAST);
            o_col_bad_mark <= (i_col_addr == `COL_BAD_MARK);
        end
    end

endmodule // nand_status_ecc_features

// ### tb/nand_status_ecc_features_props.sv
/* Checker for the status/driver/ECC feature block.
 Sees only top ports; bound in below. */
`timescale 1ns/1ps
module nand_status_ecc_features_props (
    input wire        i_sys_clk,
    input wire        i_rstn,
    input wire        i_cs_n,
    input wire [11:0] i_col_addr,
    input wire        o_miso_oe,
    input wire        o_prog_start,
    input wire        o_erase_start,
    input wire        o_read_start,
    input wire        o_reset_start,
    input wire        o_ecc_enable,
    input wire [1:0]  o_drive_strength,
    input wire [6:0]  o_drive_percent,
    input wire        o_col_protected,
    input wire        o_col_parity,
    input wire        o_col_bad_mark
);
    wire [3:0] starts = {o_prog_start, o_erase_start, o_read_start, o_reset_start};
    wire par_exp = i_col_addr >= 12'h840 && i_col_addr <= 12'h87F;
    wire prot_exp = i_col_addr < 12'h800 || (i_col_addr < 12'h880 && (i_col_addr[3:2] != 2'h0 || par_exp));
    wire [6:0] pct_exp = o_drive_strength == 2'h0 ? 7'h32 : o_drive_strength == 2'h1 ? 7'h19 :
                         o_drive_strength == 2'h2 ? 7'h4B : 7'h64;
    wire bad_exp = i_col_addr == 12'h800;
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_rstn);
    a_drive_pct_map: assert property (i_rstn |=> o_drive_percent == $past(pct_exp))
        else $error("drive percent wrong");
    a_col_protect_map: assert property (i_rstn |=> o_col_protected == $past(prot_exp))
        else $error("protect flag wrong");
    a_col_parity_map: assert property (i_rstn |=> o_col_parity == $past(par_exp))
        else $error("parity flag wrong");
    a_bad_mark_col: assert property (i_rstn |=> o_col_bad_mark == $past(bad_exp))
        else $error("bad mark flag wrong");
    a_one_op: assert property ($onehot0(starts)) else $error("two starts at once");
    a_start_pulse: assert property (|starts |=> starts == 4'h0) else $error("start too long");
    a_oe_idle: assert property (i_cs_n [*4] |-> !o_miso_oe) else $error("drives while idle");
    a_power_up: assert property (
        $rose(i_rstn) |-> o_ecc_enable && o_drive_strength == 2'h0 ##1 o_read_start)
        else $error("power-up state wrong");
    cover property (o_prog_start);
    cover property (o_reset_start);
    cover property (o_miso_oe && o_drive_percent == 7'h64);
endmodule // nand_status_ecc_features_props
bind nand_status_ecc_features nand_status_ecc_features_props i_nand_status_ecc_features_props (
    .i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_cs_n(i_cs_n), .i_col_addr(i_col_addr),
    .o_miso_oe(o_miso_oe), .o_prog_start(o_prog_start), .o_erase_start(o_erase_start),
    .o_read_start(o_read_start), .o_reset_start(o_reset_start), .o_ecc_enable(o_ecc_enable),
    .o_drive_strength(o_drive_strength), .o_drive_percent(o_drive_percent),
    .o_col_protected(o_col_protected), .o_col_parity(o_col_parity), .o_col_bad_mark(o_col_bad_mark));

// ### tb/spi_host_model.sv
/* Host controller model: mode-0 frames, 160 ns bits.
 Assumes calls start at a falling edge of i_clk. */
`timescale 1ns/1ps
module spi_host_model (
    input  wire i_clk,
    input  wire i_miso,
    output reg  o_sclk,
    output reg  o_cs_n,
    output reg  o_mosi
);
    initial {o_sclk, o_cs_n, o_mosi} = 3'h2;
    task xfer(input [31:0] d, input integer nb, input integer nr, output [7:0] rd);
        integer i;
        begin
            rd = 8'h00;
            o_cs_n = 1'b0;
            repeat (4) @(negedge i_clk);
            for (i = 0; i < 8 * (nb + nr); i = i + 1) begin
                o_mosi = (i < 8 * nb) ? d[31 - i] : ~o_mosi;
                repeat (8) @(negedge i_clk);
                o_sclk = 1'b1;
                if (i >= 8 * nb) rd = {rd[6:0], i_miso};
                repeat (8) @(negedge i_clk);
                o_sclk = 1'b0;
            end
            repeat (4) @(negedge i_clk);
            o_cs_n = 1'b1;
            o_mosi = ~o_mosi; // no stale bit left on the line
            repeat (8) @(negedge i_clk);
        end
    endtask
endmodule // spi_host_model

// ### tb/tb_nand_status_ecc_features.sv
/* Self-checking bench for the feature block.
 Host model on the pins; the bench plays the array engine. */
`timescale 1ns/1ps
module tb_nand_status_ecc_features;
    reg clk = 1'b0, rstn = 1'b0, op_done = 1'b0, op_fail = 1'b0, locked = 1'b0, pend = 1'b0;
    reg [3:0] ecc = 4'h0;
    reg [11:0] col = 12'h000;
    integer n_fail = 0, checks = 0, k;
    wire sclk, cs_n, mosi, miso, oe, ps, es, rs, xs, ecc_en, prot, par, bad;
    wire [23:0] row;
    wire [1:0] ds;
    wire [6:0] pct;
    localparam [149:0] CT = {12'h000, 3'h4, 12'h7FF, 3'h4, 12'h800, 3'h1, 12'h803, 3'h0,
        12'h804, 3'h4, 12'h813, 3'h0, 12'h814, 3'h4, 12'h840, 3'h6, 12'h87F, 3'h6, 12'h880, 3'h0};
    always #5 clk = ~clk;
    always @(posedge clk) if (ps | es | rs | xs) pend <= 1'b1;
    nand_status_ecc_features i_nand_status_ecc_features (.i_sys_clk(clk), .i_rstn(rstn),
        .i_sclk(sclk), .i_cs_n(cs_n), .i_mosi(mosi), .o_miso(miso), .o_miso_oe(oe),
        .i_op_done(op_done), .i_op_fail(op_fail), .i_ecc_bits(ecc), .i_target_locked(locked),
        .i_col_addr(col), .o_prog_start(ps), .o_erase_start(es), .o_read_start(rs),
        .o_reset_start(xs), .o_row_addr(row), .o_ecc_enable(ecc_en), .o_drive_strength(ds),
        .o_drive_percent(pct), .o_col_protected(prot), .o_col_parity(par), .o_col_bad_mark(bad));
    spi_host_model i_spi_host_model (.i_clk(clk), .i_miso(miso), .o_sclk(sclk), .o_cs_n(cs_n),
        .o_mosi(mosi));
    task stop_test;
        begin
            $display("checks %0d n_fail %0d", checks, n_fail);
            if (n_fail == 0 && checks > 0) $display("Test passed");
            else $display("Test failed");
            $finish;
        end
    endtask
    task chk(input [63:0] nm, input [7:0] e, input [7:0] g);
        begin
            checks = checks + 1;
            if (g !== e) begin
                n_fail = n_fail + 1;
                $display("[FAIL] %0s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    task cmd(input [31:0] d, input integer nb);
        reg [7:0] v;
        i_spi_host_model.xfer(d, nb, 0, v);
    endtask
    task rd(input [7:0] fa, output [7:0] v);
        i_spi_host_model.xfer({8'h0F, fa, 16'h0000}, 2, 1, v);
    endtask
    task st(input [7:0] m, output [7:0] v);
        begin
            rd(8'hC0, v);
            v = v & m;
        end
    endtask
    task op(input f, input [3:0] e);
        begin
            for (k = 0; k < 50 && !pend; k = k + 1) @(negedge clk);
            {op_done, op_fail, ecc} = {1'b1, f, e};
            @(negedge clk);
            {op_done, pend} = 2'h0;
            repeat (40) @(negedge clk); // covers the 300 ns quiet time after reset
        end
    endtask
    task t_power;
        reg [7:0] v;
        begin
            st(8'h31, v); chk("boot", 8'h01, v);
            op(1'b0, 4'h5);
            st(8'hFF, v); chk("stat_c0", 8'h50, v);
            rd(8'hF0, v); chk("stat_f0", 8'h50, v);
            $display("t_power done");
        end
    endtask
    task t_ecc;
        reg [7:0] v, x;
        reg [3:0] e, e4;
        begin
            for (e = 4'h0; e < 4'hA; e = e + 4'h1) begin
                cmd({8'h13, 24'h000040}, 4);
                st(8'hF1, v); chk("rd_start", 8'h01, v);
                chk("row_lo", 8'h40, row[7:0]);
                op(1'b0, e);
                e4 = e - 4'h4;
                x = e == 4'h0 ? 8'h00 : e < 4'h5 ? 8'h10 : e < 4'h8 ? {e4[1:0], 6'h10} :
                    e == 4'h8 ? 8'h30 : 8'h20;
                st(e < 4'h8 ? 8'hFF : 8'h3F, v); chk("ecc_st", x, v);
            end
            $display("t_ecc done");
        end
    endtask
    task t_flags;
        reg [7:0] v;
        begin
            cmd(32'h06000000, 1); st(8'h0F, v); chk("wl_set", 8'h02, v);
            cmd(32'h04000000, 1); st(8'h0F, v); chk("wl_clr", 8'h00, v);
            cmd(32'h10000100, 4); st(8'h0F, v); chk("no_latch", 8'h00, v);
            chk("row_mid", 8'h01, row[15:8]);
            cmd(32'h06000000, 1); cmd(32'h10000100, 4); op(1'b1, 4'h0);
            st(8'h0F, v); chk("p_fail", 8'h08, v);
            cmd(32'h06000000, 1); cmd(32'h10000100, 4);
            st(8'h09, v); chk("p_clr", 8'h01, v);
            op(1'b0, 4'h0);
            locked = 1'b1;
            cmd(32'h06000000, 1); cmd(32'hD8000200, 4);
            st(8'h05, v); chk("e_lock", 8'h04, v);
            locked = 1'b0;
            cmd(32'h06000000, 1); cmd(32'hD8000200, 4);
            st(8'h05, v); chk("e_clr", 8'h01, v);
            op(1'b1, 4'h0); st(8'h05, v); chk("e_fail", 8'h04, v);
            cmd(32'hFF000000, 1); op(1'b0, 4'h0);
            st(8'hFD, v); chk("rst_clr", 8'h00, v);
            $display("t_flags done");
        end
    endtask
    task t_feat;
        reg [7:0] v;
        reg [2:0] d;
        begin
            for (d = 3'h0; d < 3'h4; d = d + 3'h1) begin
                cmd({8'h1F, 8'hD0, 1'b0, d[1:0], 13'h0000}, 3);
                rd(8'hD0, v); chk("drv_rb", {1'b0, d[1:0], 5'h00}, v & 8'h60);
                chk("drv_pct", d == 3'h0 ? 8'h32 : d == 3'h1 ? 8'h19 : d == 3'h2 ? 8'h4B : 8'h64,
                    {1'b0, pct});
            end
            cmd(32'h1FB00000, 3); chk("ecc_off", 8'h00, {7'h00, ecc_en});
            cmd(32'h13000040, 4); op(1'b0, 4'h5);
            st(8'hF0, v); chk("ecc_dis", 8'h00, v);
            cmd(32'h1FB01000, 3); rd(8'hB0, v); chk("ecc_on", 8'h10, v & 8'h10);
            $display("t_feat done");
        end
    endtask
    task t_col;
        for (k = 0; k < 10; k = k + 1) begin
            col = CT[15 * k + 3 +: 12];
            repeat (2) @(negedge clk);
            chk("col_map", {5'h00, CT[15 * k +: 3]}, {5'h00, prot, par, bad});
        end
    endtask
    initial begin
        #1000000;
        n_fail = n_fail + 1;
        stop_test;
    end
    initial begin
        repeat (20) @(negedge clk);
        rstn = 1'b1;
        repeat (4) @(negedge clk);
        t_power;
        t_ecc;
        t_flags;
        t_feat;
        t_col;
        $display("t_col done");
        stop_test;
    end
endmodule // tb_nand_status_ecc_features
